// ==== hw/hsp_consts.svh ====
`ifndef HSP_CONSTS_SVH
`define HSP_CONSTS_SVH

// Number of clock outputs governed by the enable pins
`define HSP_NUM_OUTS 8
// Width of the device status vector watched for changes
`define HSP_NUM_STATUS 4
// Serial byte width and bit counter
`define HSP_BYTE_W 8
`define HSP_BIT_CNT_W 3
`define HSP_BIT_FIRST 3'h0
`define HSP_BIT_LAST 3'h7
// Enable scope defaults: primary governs all, secondary none
`define HSP_SCOPE_PRI_RST '1
`define HSP_SCOPE_SEC_RST '0

`endif

// ==== hw/hsp_pkg.sv ====
`include "hsp_consts.svh"

package hsp_pkg;

    // Reset sequencing: held, strap capture, running
    typedef enum logic [1:0]
    {
        HSP_PH_RESET = 2'h0,
        HSP_PH_STRAP = 2'h1,
        HSP_PH_RUN = 2'h3
    } hsp_phase_t;

    typedef logic [`HSP_BYTE_W-1:0] hsp_byte_t;

endpackage

// ==== hw/hsp_pins.sv ====
`timescale 1ns/100ps
// Operation
// RULE1 - Strap high selects I2C serial mode, strap low selects SPI mode.
// RULE2 - Data pin: open-drain SDA in I2C, bidirectional 3-wire SPI, input 4-wire SPI.
// RULE3 - Address/output pin is address bit one in I2C, read data out in 4-wire SPI.
// RULE4 - Address/select pin level is address bit zero in I2C mode.
// RULE5 - In SPI the host selects by pulling select low; transfers only while low.
// RULE6 - Host supplies serial clock in both modes; device never drives it.
// RULE7 - Interrupt output low whenever a device status change has occurred.
// RULE8 - Reset pin low performs full reset; all state returns to defaults. The pin leaves tx_hold, tx_tgl and the serial clock domain state as they are.
// RULE9 - All clock outputs stay disabled while reset is in effect.
// RULE10 - Primary enable pin low enables its outputs, high disables them.
// RULE11 - After reset primary enable governs all outputs; configuration may narrow it.
// RULE12 - Secondary enable pin governs nothing until configuration assigns outputs.
`include "hsp_consts.svh"

module hsp_pins #(
    parameter int NUM_OUTS = `HSP_NUM_OUTS,
    parameter int NUM_STATUS = `HSP_NUM_STATUS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // Host serial clock, its own domain, input only
    input wire logic serial_clk,
    // Pins
    input wire logic iface_i2c_sel,
    input wire logic device_reset_n,
    input wire logic output_enable_primary_n,
    input wire logic output_enable_secondary_n,
    input wire logic addr0_select_n_i,
    input wire logic sda_sdio_i,
    output logic sda_sdio_o,
    output logic sda_sdio_oe,
    input wire logic addr1_sdo_i,
    output logic addr1_sdo_o,
    output logic addr1_sdo_oe,
    output logic status_change_irq_n,
    // Core side, clk_sys domain
    input wire logic [NUM_STATUS-1:0] status_in,
    input wire logic irq_clear,
    input wire logic cfg_write,
    input wire logic [NUM_OUTS-1:0] cfg_scope_primary,
    input wire logic [NUM_OUTS-1:0] cfg_scope_secondary,
    input wire logic cfg_spi_three_wire,
    input wire logic spi_drive_sdio,
    input wire logic i2c_sda_drive_low,
    input wire hsp_pkg::hsp_byte_t tx_byte,
    input wire logic tx_load,
    output logic device_in_reset,
    output logic i2c_mode,
    output logic [1:0] i2c_addr_lo,
    output logic spi_selected,
    output hsp_pkg::hsp_byte_t rx_data,
    output logic rx_valid,
    output logic [NUM_OUTS-1:0] clk_out_en
);

    // Refuse sizes the masks cannot serve, at elaboration rather than at run time
    if (NUM_OUTS < 1 || NUM_OUTS > 32 || NUM_STATUS < 1)
    begin : g_bad_params
        $error("hsp_pins: unsupported parameter values");
    end

    // System domain state
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic sel_s1;
        logic sel_s2;
        logic a1_s1;
        logic a1_s2;
        logic a0_s1;
        logic a0_s2;
        logic oe0_s1;
        logic oe0_s2;
        logic oe1_s1;
        logic oe1_s2;
        hsp_pkg::hsp_phase_t phase;
        logic mode_i2c;
        logic three_wire;
        logic drive_sdio;
        logic sda_low;
        logic [NUM_OUTS-1:0] scope_pri;
        logic [NUM_OUTS-1:0] scope_sec;
        logic [NUM_OUTS-1:0] clk_en;
        logic [NUM_STATUS-1:0] stat_prev;
        logic irq_pend;
        logic rxt_s1;
        logic rxt_s2;
        logic rxt_s3;
        hsp_pkg::hsp_byte_t rx_data;
        logic rx_valid;
        hsp_pkg::hsp_byte_t tx_hold;
        logic tx_tgl;
    } hsp_sys_t;

    // Serial clock domain state, kept across frames
    typedef struct packed {
        logic txt_s1;
        logic txt_s2;
        logic tx_seen;
        hsp_pkg::hsp_byte_t rx_shift;
        hsp_pkg::hsp_byte_t rx_byte;
        logic rx_tgl;
        hsp_pkg::hsp_byte_t tx_shift;
    } hsp_lnk_t;

    hsp_sys_t sys_r;
    hsp_sys_t sys_nxt;
    hsp_lnk_t lnk_r;
    hsp_lnk_t lnk_nxt;
    logic [`HSP_BIT_CNT_W-1:0] bit_cnt_r;
    logic frame_clr;
    logic in_reset;
    logic [NUM_OUTS-1:0] dis_mask;

    assign in_reset = (sys_r.phase != hsp_pkg::HSP_PH_RUN);

    // Enable pins are active low: a high level disables the scoped outputs
    assign dis_mask = (sys_r.scope_pri & {NUM_OUTS{sys_r.oe0_s2}}) // RULE10 RULE11
        | (sys_r.scope_sec & {NUM_OUTS{sys_r.oe1_s2}}); // RULE12

    // System domain next state
    always_comb
    begin
        sys_nxt = sys_r;
        // Two-flop synchronisers for every control pin level; the data pin goes only to the serial clock domain
        sys_nxt.rst_s1 = device_reset_n;
        sys_nxt.rst_s2 = sys_r.rst_s1;
        sys_nxt.sel_s1 = iface_i2c_sel;
        sys_nxt.sel_s2 = sys_r.sel_s1;
        sys_nxt.a1_s1 = addr1_sdo_i;
        sys_nxt.a1_s2 = sys_r.a1_s1;
        sys_nxt.a0_s1 = addr0_select_n_i;
        sys_nxt.a0_s2 = sys_r.a0_s1;
        sys_nxt.oe0_s1 = output_enable_primary_n;
        sys_nxt.oe0_s2 = sys_r.oe0_s1;
        sys_nxt.oe1_s1 = output_enable_secondary_n;
        sys_nxt.oe1_s2 = sys_r.oe1_s1;
        sys_nxt.rxt_s1 = lnk_r.rx_tgl;
        sys_nxt.rxt_s2 = sys_r.rxt_s1;
        sys_nxt.rxt_s3 = sys_r.rxt_s2;
        sys_nxt.stat_prev = status_in;
        sys_nxt.rx_valid = 1'b0;

        // Reset sequencing; strap taken in the strap phase, two cycles after the synchronised pin releases
        unique case (sys_r.phase)
            hsp_pkg::HSP_PH_RESET:
            begin
                if (sys_r.rst_s2)
                begin
                    sys_nxt.phase = hsp_pkg::HSP_PH_STRAP;
                end
            end
            hsp_pkg::HSP_PH_STRAP:
            begin
                sys_nxt.mode_i2c = sys_r.sel_s2; // RULE1
                sys_nxt.phase = hsp_pkg::HSP_PH_RUN;
            end
            hsp_pkg::HSP_PH_RUN:
            begin
                sys_nxt.phase = hsp_pkg::HSP_PH_RUN;
            end
            default:
            begin
                sys_nxt.phase = hsp_pkg::HSP_PH_RESET;
            end
        endcase

        if (!in_reset)
        begin
            // Configuration port
            if (cfg_write)
            begin
                sys_nxt.scope_pri = cfg_scope_primary; // RULE11
                sys_nxt.scope_sec = cfg_scope_secondary; // RULE12
                sys_nxt.three_wire = cfg_spi_three_wire;
            end
            sys_nxt.drive_sdio = spi_drive_sdio;
            sys_nxt.sda_low = i2c_sda_drive_low & sys_r.mode_i2c;
            sys_nxt.clk_en = ~dis_mask; // RULE10
            // Change detect; a new change beats a clear in the same cycle
            sys_nxt.irq_pend = (status_in != sys_r.stat_prev)
                | (sys_r.irq_pend & !irq_clear); // RULE7
            // Received byte; bytes clocked in I2C mode are dropped
            if ((sys_r.rxt_s2 != sys_r.rxt_s3) && !sys_r.mode_i2c)
            begin
                sys_nxt.rx_data = lnk_r.rx_byte;
                sys_nxt.rx_valid = 1'b1;
            end
            if (tx_load)
            begin
                sys_nxt.tx_hold = tx_byte;
                sys_nxt.tx_tgl = !sys_r.tx_tgl;
            end
        end

        // Reset pin low forces every setting back to its default
        if (!sys_r.rst_s2)
        begin
            sys_nxt.phase = hsp_pkg::HSP_PH_RESET; // RULE8
            sys_nxt.scope_pri = `HSP_SCOPE_PRI_RST; // RULE8 RULE11
            sys_nxt.scope_sec = `HSP_SCOPE_SEC_RST; // RULE12
            sys_nxt.three_wire = 1'b0;
            sys_nxt.drive_sdio = 1'b0;
            sys_nxt.sda_low = 1'b0;
            sys_nxt.clk_en = '0; // RULE9
            sys_nxt.irq_pend = 1'b0;
            sys_nxt.rx_data = '0;
        end
    end

    // System domain registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sys_r <= '0;
            sys_r.sel_s1 <= 1'b1;
            sys_r.sel_s2 <= 1'b1;
            sys_r.mode_i2c <= 1'b1;
            sys_r.scope_pri <= `HSP_SCOPE_PRI_RST;
            sys_r.scope_sec <= `HSP_SCOPE_SEC_RST;
            sys_r.a0_s1 <= 1'b1;
            sys_r.a0_s2 <= 1'b1;
            sys_r.phase <= hsp_pkg::HSP_PH_RESET;
        end
        else
        begin
            sys_r <= sys_nxt;
        end
    end

    // Bit position is frame scoped: select high or reset clears it,
    // since the host clock stands still between frames
    assign frame_clr = !rst_n || addr0_select_n_i; // RULE5

    always_ff @(posedge serial_clk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            bit_cnt_r <= `HSP_BIT_FIRST;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // Serial clock domain next state; clocked on every rising host clock edge, bit position advances only while selected
    always_comb
    begin
        lnk_nxt = lnk_r;
        lnk_nxt.txt_s1 = sys_r.tx_tgl;
        lnk_nxt.txt_s2 = lnk_r.txt_s1;
        lnk_nxt.rx_shift = {lnk_r.rx_shift[`HSP_BYTE_W-2:0], sda_sdio_i}; // RULE2
        lnk_nxt.tx_shift = {lnk_r.tx_shift[`HSP_BYTE_W-2:0], 1'b0};
        if (bit_cnt_r == `HSP_BIT_LAST)
        begin
            lnk_nxt.rx_byte = lnk_nxt.rx_shift;
            lnk_nxt.rx_tgl = !lnk_r.rx_tgl;
            // Next byte loads only if the core offered a fresh one
            if (lnk_r.txt_s2 != lnk_r.tx_seen)
            begin
                lnk_nxt.tx_shift = sys_r.tx_hold;
                lnk_nxt.tx_seen = lnk_r.txt_s2;
            end
        end
    end

    // Serial clock domain registers
    always_ff @(posedge serial_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lnk_r <= '0;
        end
        else
        begin
            lnk_r <= lnk_nxt;
        end
    end

    // Pin drivers; serial clock is input only and never driven
    always_comb
    begin
        sda_sdio_o = 1'b0; // RULE6
        sda_sdio_oe = 1'b0;
        addr1_sdo_o = lnk_r.tx_shift[`HSP_BYTE_W-1];
        addr1_sdo_oe = 1'b0;
        if (sys_r.mode_i2c)
        begin
            // Open drain: only ever pull low
            sda_sdio_oe = sys_r.sda_low; // RULE2
        end
        else if (!addr0_select_n_i && !in_reset)
        begin
            if (sys_r.three_wire)
            begin
                sda_sdio_o = lnk_r.tx_shift[`HSP_BYTE_W-1];
                sda_sdio_oe = sys_r.drive_sdio; // RULE2 RULE5
            end
            else
            begin
                addr1_sdo_oe = 1'b1; // RULE3 RULE5
            end
        end
    end

    // Core side outputs and the interrupt pin
    assign device_in_reset = in_reset;
    assign i2c_mode = sys_r.mode_i2c;
    assign i2c_addr_lo = sys_r.mode_i2c ? {sys_r.a1_s2, sys_r.a0_s2} : 2'h0; // RULE3 RULE4
    assign spi_selected = !sys_r.mode_i2c && !sys_r.a0_s2 && !in_reset; // RULE5
    assign rx_data = sys_r.rx_data;
    assign rx_valid = sys_r.rx_valid;
    assign clk_out_en = sys_r.clk_en; // RULE9
    assign status_change_irq_n = !sys_r.irq_pend; // RULE7

endmodule // hsp_pins

// ==== tb/hsp_pins_checker.sv ====
`timescale 1ns/100ps
module hsp_pins_checker #(
    parameter int NUM_OUTS = 8,
    parameter int NUM_STATUS = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic addr0_select_n_i,
    input wire logic addr1_sdo_i,
    input wire logic device_reset_n,
    input wire logic output_enable_primary_n,
    input wire logic [NUM_STATUS-1:0] status_in,
    input wire logic cfg_write,
    input wire logic sda_sdio_o,
    input wire logic sda_sdio_oe,
    input wire logic addr1_sdo_oe,
    input wire logic status_change_irq_n,
    input wire logic device_in_reset,
    input wire logic i2c_mode,
    input wire logic [1:0] i2c_addr_lo,
    input wire logic spi_selected,
    input wire logic [NUM_OUTS-1:0] clk_out_en
);
    logic cfg_seen_r;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Scopes narrowed since last reset; until then defaults must hold
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_seen_r <= 1'b0;
        end
        else
        begin
            cfg_seen_r <= (cfg_seen_r || cfg_write) && !device_in_reset;
        end
    end
    // Steps: running with steady pins long enough for the sync stages
    sequence pins_settled;
        (!device_in_reset && $stable(output_enable_primary_n)) [*4];
    endsequence
    sequence addr_settled;
        (i2c_mode && !device_in_reset && $stable({addr1_sdo_i, addr0_select_n_i})) [*4];
    endsequence
    outputs_off_a:
        assert property (device_in_reset |-> clk_out_en == '0) else $error("outputs on in reset");
    irq_raise_a:
        assert property (!device_in_reset && $changed(status_in) |=> !status_change_irq_n) else $error("no irq");
    irq_cause_a:
        assert property (status_change_irq_n && !$changed(status_in) |=> status_change_irq_n) else $error("stray irq");
    addr_bits_a:
        assert property (addr_settled |-> i2c_addr_lo == {addr1_sdo_i, addr0_select_n_i}) else $error("bad addr");
    sdo_quiet_a:
        assert property (i2c_mode |-> !addr1_sdo_oe) else $error("sdo driven in i2c");
    sda_open_a:
        assert property (sda_sdio_oe && i2c_mode |-> !sda_sdio_o) else $error("sda driven high");
    select_gate_a:
        assert property (addr0_select_n_i [*3] |-> !spi_selected && !addr1_sdo_oe && (i2c_mode || !sda_sdio_oe))
            else $error("unselected");
    default_scope_a:
        assert property (pins_settled ##0 !cfg_seen_r |-> clk_out_en == {NUM_OUTS{!output_enable_primary_n}})
            else $error("default scope");
    reset_pin_a:
        assert property (!device_reset_n [*4] |-> device_in_reset && status_change_irq_n) else $error("pin reset");
endmodule // hsp_pins_checker

// ==== tb/hsp_host_model.sv ====
`timescale 1ns/100ps
module hsp_host_model (
    output logic serial_clk,
    output logic select_n,
    output logic mosi,
    input wire logic miso
);
    // Idle: clock still, device deselected
    initial
    begin
        serial_clk = 1'b0;
        select_n = 1'b1;
        mosi = 1'b0;
    end
    // Two-byte frame, MSB first; odd start offset keeps phase unrelated
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        #3.3 select_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi = tx[i];
            #40 serial_clk = 1'b1;
            #20 rx = {rx[14:0], miso};
            #20 serial_clk = 1'b0;
        end
        #40 select_n = 1'b1;
        mosi = ~mosi; // Released line must not show stale data
    endtask
endmodule // hsp_host_model

// ==== tb/tb_hsp_pins.sv ====
`timescale 1ns/100ps
module tb_hsp_pins;
    logic clk_sys, rst_n, iface_i2c_sel, device_reset_n, output_enable_primary_n, output_enable_secondary_n;
    logic irq_clear, cfg_write, cfg_spi_three_wire, spi_drive_sdio, i2c_sda_drive_low, tx_load, a0_drv, a1_drv;
    logic sda_sdio_o, sda_sdio_oe, addr1_sdo_o, addr1_sdo_oe, status_change_irq_n, device_in_reset, i2c_mode;
    logic spi_selected, rx_valid, serial_clk, sel_n, mosi, sda_w, a1_w, a0_w;
    logic [3:0] status_in;
    logic [7:0] cfg_scope_primary, cfg_scope_secondary, clk_out_en;
    logic [1:0] i2c_addr_lo;
    logic [15:0] miso;
    logic [15:0] sdio_q;
    hsp_pkg::hsp_byte_t tx_byte, rx_data;
    hsp_pkg::hsp_byte_t rxq[$];
    int mismatches = 0, cmp_count = 0, cycles = 0;
    // Pin levels; SDA pulled up in I2C, idle SPI_DATA_OUT shows no stale value
    assign sda_w = sda_sdio_oe ? sda_sdio_o : (i2c_mode ? 1'b1 : mosi);
    assign a1_w = addr1_sdo_oe ? addr1_sdo_o : (i2c_mode ? a1_drv : ~addr1_sdo_o);
    assign a0_w = a0_drv & sel_n;
    hsp_pins DUT (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .serial_clk(serial_clk),
        .iface_i2c_sel(iface_i2c_sel),
        .device_reset_n(device_reset_n),
        .output_enable_primary_n(output_enable_primary_n),
        .output_enable_secondary_n(output_enable_secondary_n),
        .addr0_select_n_i(a0_w),
        .sda_sdio_i(sda_w),
        .sda_sdio_o(sda_sdio_o),
        .sda_sdio_oe(sda_sdio_oe),
        .addr1_sdo_i(a1_w),
        .addr1_sdo_o(addr1_sdo_o),
        .addr1_sdo_oe(addr1_sdo_oe),
        .status_change_irq_n(status_change_irq_n),
        .status_in(status_in),
        .irq_clear(irq_clear),
        .cfg_write(cfg_write),
        .cfg_scope_primary(cfg_scope_primary),
        .cfg_scope_secondary(cfg_scope_secondary),
        .cfg_spi_three_wire(cfg_spi_three_wire),
        .spi_drive_sdio(spi_drive_sdio),
        .i2c_sda_drive_low(i2c_sda_drive_low),
        .tx_byte(tx_byte),
        .tx_load(tx_load),
        .device_in_reset(device_in_reset),
        .i2c_mode(i2c_mode),
        .i2c_addr_lo(i2c_addr_lo),
        .spi_selected(spi_selected),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .clk_out_en(clk_out_en)
    );
    hsp_host_model host (.serial_clk(serial_clk), .select_n(sel_n), .mosi(mosi), .miso(a1_w));
    // System clock
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Collect received bytes; cut a hung run short
    always @(posedge clk_sys)
    begin
        cycles++;
        if (rx_valid === 1'b1)
            rxq.push_back(rx_data);
        if (cycles == 5000)
        begin
            mismatches++;
            summarize();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic [16:0] v);
        {cfg_scope_primary, cfg_scope_secondary, cfg_spi_three_wire} = v;
        cfg_write = 1'b1;
        step(1);
        cfg_write = 1'b0;
    endtask
    task automatic t_i2c();
        chk(i2c_mode, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            {a1_drv, a0_drv} = i[1:0];
            step(4);
            chk(i2c_addr_lo, i[1:0]);
        end
        i2c_sda_drive_low = 1'b1;
        step(2);
        chk({sda_sdio_oe, sda_sdio_o, addr1_sdo_oe}, 3'h4);
        i2c_sda_drive_low = 1'b0;
        rxq.delete();
        host.frame(16'h3CC3, miso);
        step(8);
        chk(16'(rxq.size()), 16'h0);
        $display("t_i2c done");
    endtask
    task automatic t_enables();
        for (int k = 0; k < 2; k++)
        begin
            for (int i = 0; i < 4; i++)
            begin
                {output_enable_primary_n, output_enable_secondary_n} = i[1:0];
                step(5);
                chk(clk_out_en, k ? {{4{~i[0]}}, {4{~i[1]}}} : {8{~i[1]}});
            end
            cfg(17'h1FE0);
        end
        $display("t_enables done");
    endtask
    task automatic t_irq();
        {output_enable_primary_n, output_enable_secondary_n} = 2'h1;
        status_in = 4'h5;
        step(2);
        chk(status_change_irq_n, 1'b0);
        irq_clear = 1'b1;
        step(1);
        irq_clear = 1'b0;
        step(1);
        chk(status_change_irq_n, 1'b1);
        // A change and a clear in one cycle: the change must win
        {status_in, irq_clear} = 5'hD;
        step(1);
        irq_clear = 1'b0;
        step(1);
        chk(status_change_irq_n, 1'b0);
        {status_in, iface_i2c_sel, device_reset_n} = 6'h28;
        step(4);
        chk({status_change_irq_n, device_in_reset, clk_out_en}, 10'h300);
        device_reset_n = 1'b1;
        step(8);
        chk({status_change_irq_n, device_in_reset, i2c_mode, clk_out_en}, 11'h4FF);
        $display("t_irq done");
    endtask
    task automatic t_spi();
        tx_byte = 8'hA5;
        tx_load = 1'b1;
        step(1);
        tx_load = 1'b0;
        rxq.delete();
        host.frame(16'h3CC3, miso);
        step(8);
        chk(miso[15:1], {7'h0, 8'hA5});
        chk({rxq[0], rxq[1]}, 16'h3CC3);
        cfg(17'h1FE01);
        rxq.delete();
        host.frame(16'h5A96, miso);
        step(8);
        chk({rxq[0], rxq[1]}, 16'h5A96);
        // 3-wire with the device driving the data pin back to the host
        tx_byte = 8'h96;
        {tx_load, spi_drive_sdio} = 2'h3;
        step(1);
        tx_load = 1'b0;
        step(1);
        fork
            host.frame(16'h0000, miso);
            begin
                @(negedge sel_n);
                step(3);
                chk({spi_selected, sda_sdio_oe}, 2'h3);
                repeat (16)
                begin
                    @(posedge serial_clk);
                    #20 sdio_q = {sdio_q[14:0], sda_w};
                end
            end
        join
        step(2);
        chk(sda_sdio_oe, 1'b0);
        chk(sdio_q[15:1], {7'h0, 8'h96});
        spi_drive_sdio = 1'b0;
        $display("t_spi done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Reset, then scenarios in turn
    initial
    begin
        rst_n = 1'b0;
        {iface_i2c_sel, device_reset_n, a0_drv, a1_drv, tx_byte} = 12'hF00;
        {output_enable_primary_n, output_enable_secondary_n, irq_clear, cfg_write} = 4'h0;
        {cfg_spi_three_wire, spi_drive_sdio, i2c_sda_drive_low, tx_load} = 4'h0;
        {status_in, cfg_scope_primary, cfg_scope_secondary} = 20'h0;
        step(5);
        rst_n = 1'b1;
        step(6);
        t_i2c();
        t_enables();
        t_irq();
        t_spi();
        summarize();
    end
endmodule // tb_hsp_pins
bind hsp_pins hsp_pins_checker #(.NUM_OUTS(NUM_OUTS), .NUM_STATUS(NUM_STATUS)) u_chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .addr0_select_n_i(addr0_select_n_i),
    .addr1_sdo_i(addr1_sdo_i),
    .device_reset_n(device_reset_n),
    .output_enable_primary_n(output_enable_primary_n),
    .status_in(status_in),
    .cfg_write(cfg_write),
    .sda_sdio_o(sda_sdio_o),
    .sda_sdio_oe(sda_sdio_oe),
    .addr1_sdo_oe(addr1_sdo_oe),
    .status_change_irq_n(status_change_irq_n),
    .device_in_reset(device_in_reset),
    .i2c_mode(i2c_mode),
    .i2c_addr_lo(i2c_addr_lo),
    .spi_selected(spi_selected),
    .clk_out_en(clk_out_en)
);
